// ---- cpu_regs.v ----
// dedicated cpu registers, condition codes and banked general-purpose registers
// Behaviour
// (RULE1) 16-bit program counter addresses next instruction
// (RULE2) 16-bit accumulator, 8-bit ops use low byte
// (RULE3) 16-bit temp accumulator is second operand
// (RULE4) 16-bit index register for indexed addressing
// (RULE5) 16-bit extra pointer supplies memory address
// (RULE6) 16-bit stack pointer marks stack location
// (RULE7) status word: bank pointer high, flags low
// (RULE8) half-carry from carry/borrow bit 3 to 4
// (RULE9) interrupts only while enable flag set; reset clears
// (RULE10) admit request only above current level field
// (RULE11) negative flag copies result msb
// (RULE12) zero flag set on zero result
// (RULE13) overflow flag on two's-complement overflow
// (RULE14) carry flag on carry/borrow out of bit 7
// (RULE15) shifts put shifted-out bit in carry
// (RULE16) 8-bit registers, eight per bank, 32 banks
// (RULE17) active bank address derived from bank pointer
// (RULE18) banks lie inside ram 0080H to 027FH
// (RULE19) bank base is area base plus pointer times eight
// (RULE20) unaffected flags hold; update at instruction end
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "cpu_regs_defs.vh"

module cpu_regs #(
    parameter NUM_BANKS = 32,
    parameter BANK_REGS = 8
) (
    // clock, reset, enable
    input wire mclk,
    input wire reset,
    input wire clkEn,
    // software register port
    input wire [3:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdData,
    // instruction datapath
    input wire pcInc,
    input wire aluGo,
    input wire [2:0] aluOp,
    input wire [4:0] flagMask,
    // interrupt admission
    input wire irqReq,
    input wire [1:0] irqLevel,
    output wire irqAccept,
    // general-purpose register access in the active bank
    input wire [2:0] gprSel,
    input wire gprWr,
    input wire gprRd,
    input wire [7:0] gprWrData,
    output reg [7:0] gprRdData,
    output wire [15:0] gprAddr,
    // register views for address generation
    output wire [15:0] instrPointer,
    output wire [15:0] indexReg,
    output wire [15:0] extraPointer,
    output wire [15:0] stackTop,
    output wire [15:0] statusWord
);

    localparam BANK_BITS = 5;
    localparam GPR_WORDS = NUM_BANKS * BANK_REGS;
    // sized copy of the status reset value so each half can be sliced without truncation
    localparam [15:0] RST_STATUS = `RST_STATUS_WORD;

    reg [15:0] instrPointer_ff;
    reg [15:0] accumulator_ff;
    reg [15:0] tempAcc_ff;
    reg [15:0] indexReg_ff;
    reg [15:0] extraPointer_ff;
    reg [15:0] stackTop_ff;
    reg [7:0] bankSelect_ff;
    reg [7:0] condFlags_ff;
    reg [7:0] gprMem [0:GPR_WORDS-1];

    reg [15:0] nxt_accumulator;
    reg [7:0] nxt_condFlags;
    reg [7:0] nxt_bankSelect;
    reg [15:0] nxt_regRdData;
    reg [8:0] aluSum;
    reg [7:0] aluRes;
    reg aluCarry;
    reg aluHalf;
    reg aluOvf;
    reg [7:0] opA;
    reg [7:0] opT;

    wire [BANK_BITS-1:0] activeBank;
    wire [15:0] bankBase;
    wire [7:0] gprIndex;

    assign instrPointer = instrPointer_ff; // (RULE1)
    assign indexReg = indexReg_ff; // (RULE4)
    assign extraPointer = extraPointer_ff; // (RULE5)
    assign stackTop = stackTop_ff; // (RULE6)
    assign statusWord = {bankSelect_ff, condFlags_ff}; // (RULE7)

    // only the low five pointer bits select one of the 32 banks
    assign activeBank = bankSelect_ff[BANK_BITS-1:0]; // (RULE16)
    // 32 banks of 8 bytes fill 0100H..01FFH, inside the on-chip ram
    assign bankBase = `BANK_AREA_BASE + {8'h00, activeBank, 3'h0}; // (RULE19) (RULE18)
    assign gprAddr = bankBase + {13'h0000, gprSel}; // (RULE17)
    assign gprIndex = {activeBank, gprSel}; // (RULE16)

    // lower level code means higher priority, so admit strictly smaller codes
    assign irqAccept = irqReq & condFlags_ff[`CC_IEN] &
        (irqLevel < {condFlags_ff[`CC_IL_HI], condFlags_ff[`CC_IL_LO]}); // (RULE9) (RULE10)

    // 8-bit arithmetic on the low bytes of accumulator and temp accumulator
    always @* begin
        opA = accumulator_ff[7:0]; // (RULE2)
        opT = tempAcc_ff[7:0]; // (RULE3)
        aluSum = 9'h000;
        aluRes = 8'h00;
        aluCarry = condFlags_ff[`CC_CARRY];
        aluHalf = 1'b0;
        aluOvf = 1'b0;
        case (aluOp)
            `OP_ADD: begin
                aluSum = {1'b0, opA} + {1'b0, opT};
                aluRes = aluSum[7:0];
                aluCarry = aluSum[8]; // (RULE14)
                aluHalf = ({1'b0, opA[3:0]} + {1'b0, opT[3:0]}) > 5'h0F; // (RULE8)
                aluOvf = (opA[7] == opT[7]) && (aluRes[7] != opA[7]); // (RULE13)
            end
            `OP_SUB: begin
                aluSum = {1'b0, opA} - {1'b0, opT};
                aluRes = aluSum[7:0];
                aluCarry = aluSum[8]; // (RULE14)
                aluHalf = opA[3:0] < opT[3:0]; // (RULE8)
                aluOvf = (opA[7] != opT[7]) && (aluRes[7] != opA[7]); // (RULE13)
            end
            `OP_AND: begin
                aluRes = opA & opT;
            end
            `OP_OR: begin
                aluRes = opA | opT;
            end
            `OP_SHL: begin
                // rotate through carry so multi-byte shifts chain
                aluRes = {opA[6:0], condFlags_ff[`CC_CARRY]};
                aluCarry = opA[7]; // (RULE15)
            end
            `OP_SHR: begin
                aluRes = {condFlags_ff[`CC_CARRY], opA[7:1]};
                aluCarry = opA[0]; // (RULE15)
            end
            default: begin
                aluRes = opA;
            end
        endcase
    end

    // software writes first, then an instruction ending in the same cycle wins the flags its flagMask selects
    always @* begin
        nxt_accumulator = accumulator_ff;
        nxt_condFlags = condFlags_ff;
        nxt_bankSelect = bankSelect_ff;
        if (regWr && regAddr == `OFS_ACCUMULATOR) begin
            nxt_accumulator = regWrData;
        end
        if (regWr && regAddr == `OFS_STATUS_WORD) begin
            nxt_bankSelect = regWrData[15:8]; // (RULE7)
            nxt_condFlags = regWrData[7:0];
        end
        if (aluGo) begin
            // upper accumulator byte is left alone by 8-bit operations
            // a software write to the upper byte in the same cycle still lands
            nxt_accumulator = {nxt_accumulator[15:8], aluRes}; // (RULE2)
            if (flagMask[`FM_HALF]) begin
                nxt_condFlags[`CC_HALF] = aluHalf; // (RULE8) (RULE20)
            end
            if (flagMask[`FM_NEG]) begin
                nxt_condFlags[`CC_NEG] = aluRes[7]; // (RULE11) (RULE20)
            end
            if (flagMask[`FM_ZERO]) begin
                nxt_condFlags[`CC_ZERO] = (aluRes == 8'h00); // (RULE12) (RULE20)
            end
            if (flagMask[`FM_OVF]) begin
                nxt_condFlags[`CC_OVF] = aluOvf; // (RULE13) (RULE20)
            end
            if (flagMask[`FM_CARRY]) begin
                nxt_condFlags[`CC_CARRY] = aluCarry; // (RULE14) (RULE15) (RULE20)
            end
        end
    end

    // read mux; unmapped offsets read as zero
    always @* begin
        case (regAddr)
            `OFS_INSTR_POINTER: nxt_regRdData = instrPointer_ff;
            `OFS_ACCUMULATOR: nxt_regRdData = accumulator_ff;
            `OFS_TEMP_ACC: nxt_regRdData = tempAcc_ff;
            `OFS_INDEX_REG: nxt_regRdData = indexReg_ff;
            `OFS_EXTRA_POINTER: nxt_regRdData = extraPointer_ff;
            `OFS_STACK_TOP: nxt_regRdData = stackTop_ff;
            `OFS_STATUS_WORD: nxt_regRdData = {bankSelect_ff, condFlags_ff};
            `OFS_BANK_BASE: nxt_regRdData = bankBase;
            default: nxt_regRdData = 16'h0000;
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            instrPointer_ff <= `RST_INSTR_POINTER;
            accumulator_ff <= `RST_WORD;
            tempAcc_ff <= `RST_WORD;
            indexReg_ff <= `RST_WORD;
            extraPointer_ff <= `RST_WORD;
            stackTop_ff <= `RST_WORD;
            bankSelect_ff <= RST_STATUS[15:8];
            condFlags_ff <= RST_STATUS[7:0]; // (RULE9)
            regRdData <= 16'h0000;
            gprRdData <= 8'h00;
        end else if (clkEn) begin
            if (regWr && regAddr == `OFS_INSTR_POINTER) begin
                instrPointer_ff <= regWrData; // (RULE1)
            end else if (pcInc) begin
                instrPointer_ff <= instrPointer_ff + 16'h0001; // (RULE1)
            end
            if (regWr && regAddr == `OFS_TEMP_ACC) begin
                tempAcc_ff <= regWrData; // (RULE3)
            end
            if (regWr && regAddr == `OFS_INDEX_REG) begin
                indexReg_ff <= regWrData; // (RULE4)
            end
            if (regWr && regAddr == `OFS_EXTRA_POINTER) begin
                extraPointer_ff <= regWrData; // (RULE5)
            end
            if (regWr && regAddr == `OFS_STACK_TOP) begin
                stackTop_ff <= regWrData; // (RULE6)
            end
            accumulator_ff <= nxt_accumulator;
            condFlags_ff <= nxt_condFlags; // (RULE20)
            bankSelect_ff <= nxt_bankSelect;
            // data is only guaranteed in the cycle after the strobe
            regRdData <= regRd ? nxt_regRdData : 16'h0000;
            if (gprRd) begin
                gprRdData <= gprMem[gprIndex]; // (RULE16)
            end
        end
    end

    // ram array carries no reset, like the on-chip ram it models
    always @(posedge mclk) begin
        if (clkEn && gprWr) begin
            gprMem[gprIndex] <= gprWrData; // (RULE16)
        end
    end

endmodule // cpu_regs

// ---- cpu_regs_defs.vh ----
// constants for the cpu dedicated register and condition-code block
`ifndef CPU_REGS_DEFS_VH
`define CPU_REGS_DEFS_VH

// register port offsets (word index on regAddr)
`define OFS_INSTR_POINTER 4'h0
`define OFS_ACCUMULATOR 4'h1
`define OFS_TEMP_ACC 4'h2
`define OFS_INDEX_REG 4'h3
`define OFS_EXTRA_POINTER 4'h4
`define OFS_STACK_TOP 4'h5
`define OFS_STATUS_WORD 4'h6
`define OFS_BANK_BASE 4'h7

// condition-code bit positions within the low byte of the status word
`define CC_HALF 7
`define CC_IEN 6
`define CC_IL_HI 5
`define CC_IL_LO 4
`define CC_NEG 3
`define CC_ZERO 2
`define CC_OVF 1
`define CC_CARRY 0

// flag-update mask bit positions
`define FM_HALF 4
`define FM_NEG 3
`define FM_ZERO 2
`define FM_OVF 1
`define FM_CARRY 0

// reset values
`define RST_INSTR_POINTER 16'h0000
`define RST_WORD 16'h0000
`define RST_STATUS_WORD 16'h0030

// operation codes of the arithmetic request
`define OP_ADD 3'h0
`define OP_SUB 3'h1
`define OP_AND 3'h2
`define OP_OR 3'h3
`define OP_SHL 3'h4
`define OP_SHR 3'h5

// register bank geometry and location in on-chip ram
`define RAM_START 16'h0080
`define RAM_END 16'h027F
`define BANK_AREA_BASE 16'h0100
`define BANK_SHIFT 3

`endif

// ---- cpu_regs_checker.sv ----
// concurrent checks on the ports of the cpu register block
module cpu_regs_checker (
    // clock and reset
    input wire mclk,
    input wire reset,
    input wire clkEn,
    // register port
    input wire [3:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [15:0] regRdData,
    // datapath and interrupt
    input wire pcInc,
    input wire aluGo,
    input wire [4:0] flagMask,
    input wire irqReq,
    input wire [1:0] irqLevel,
    input wire irqAccept,
    // bank access and views
    input wire [2:0] gprSel,
    input wire [15:0] gprAddr,
    input wire [15:0] instrPointer,
    input wire [15:0] stackTop,
    input wire [15:0] statusWord
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence rdStatus; clkEn && regRd && regAddr == 4'h6; endsequence
    sequence wrStack; clkEn && regWr && regAddr == 4'h5; endsequence
    sequence pcStep; clkEn && pcInc && !(regWr && regAddr == 4'h0); endsequence
    status_read_a: assert property (rdStatus |=> regRdData == $past(statusWord))
        else $error("status read data differs");
    read_idle_a: assert property ($past(clkEn) && !$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not idle");
    irq_admit_a: assert property (irqAccept == (irqReq && statusWord[6] && irqLevel < statusWord[5:4]))
        else $error("interrupt admission wrong");
    bank_addr_a: assert property (gprAddr == 16'h0100 + {8'h00, statusWord[12:8], 3'h0} + {13'h0000, gprSel})
        else $error("bank address wrong");
    ram_range_a: assert property (gprAddr >= 16'h0080 && gprAddr <= 16'h027F)
        else $error("bank address outside ram");
    pc_step_a: assert property (pcStep |=> instrPointer == $past(instrPointer) + 16'h0001)
        else $error("program counter did not step");
    stack_write_a: assert property (wrStack |=> stackTop == $past(regWrData))
        else $error("stack write lost");
    flag_hold_a: assert property (clkEn && aluGo && flagMask == 5'h00 && !regWr |=> $stable(statusWord))
        else $error("unmasked flags changed");
    reset_flags_a: assert property ($past(reset) && $past(clkEn) |-> statusWord == 16'h0030)
        else $error("status not at reset value");
endmodule // cpu_regs_checker

bind cpu_regs cpu_regs_checker u_cpu_regs_checker (.mclk, .reset, .clkEn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .pcInc, .aluGo, .flagMask, .irqReq, .irqLevel, .irqAccept, .gprSel, .gprAddr, .instrPointer,
    .stackTop, .statusWord);

// ---- cpu_regs_tb.sv ----
// self-checking testbench for the cpu register block
`include "cpu_regs_defs.vh"
module cpu_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset, clkEn, regWr, regRd, pcInc, aluGo, irqReq, gprWr, gprRd, irqAccept;
    logic [3:0] regAddr;
    logic [15:0] regWrData, regRdData, gprAddr, instrPointer, indexReg, extraPointer, stackTop, statusWord;
    logic [2:0] aluOp, gprSel;
    logic [4:0] flagMask;
    logic [1:0] irqLevel;
    logic [7:0] gprWrData, gprRdData;
    int nMismatch = 0;
    int numChecks = 0;
    cpu_regs u_cpu_regs (.mclk, .reset, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pcInc, .aluGo,
        .aluOp, .flagMask, .irqReq, .irqLevel, .irqAccept, .gprSel, .gprWr, .gprRd, .gprWrData, .gprRdData,
        .gprAddr, .instrPointer, .indexReg, .extraPointer, .stackTop, .statusWord);
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobes drop with a spare edge after, so back-to-back calls never re-drive in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge mclk);
        regWr <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge mclk);
        regRd <= 1'h0;
        #1 chk(nm, e, regRdData);
        @(posedge mclk);
    endtask
    task automatic t_alu(input logic [7:0] pre, input logic [15:0] a, input logic [7:0] t, input logic [2:0] op,
        input logic [4:0] m, input logic [15:0] ea, input logic [7:0] ef);
        wr(4'h6, {8'h00, pre});
        wr(4'h1, a);
        wr(4'h2, {8'h00, t});
        aluOp <= op;
        flagMask <= m;
        aluGo <= 1'h1;
        @(posedge mclk);
        aluGo <= 1'h0;
        @(posedge mclk);
        rd(4'h1, ea, "acc");
        rd(4'h6, {8'h00, ef}, "flags");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            wr(i[3:0], 16'h1230 + 16'(i));
        end
        wr(4'h8, 16'hFFFF);
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0], 16'h1230 + 16'(i), "reg");
        end
        rd(4'h8, 16'h0000, "unmapped");
        chk("index", 16'h1233, indexReg);
        chk("extra", 16'h1234, extraPointer);
        chk("stack", 16'h1235, stackTop);
        pcInc <= 1'h1;
        repeat (2) @(posedge mclk);
        pcInc <= 1'h0;
        @(posedge mclk);
        rd(4'h0, 16'h1232, "pc");
        clkEn <= 1'h0;
        pcInc <= 1'h1;
        @(posedge mclk);
        pcInc <= 1'h0;
        clkEn <= 1'h1;
        @(posedge mclk);
        #1 chk("pcfrozen", 16'h1232, instrPointer);
    endtask
    task automatic t_irq;
        wr(4'h6, 16'h0060);
        irqReq <= 1'h1;
        for (int l = 0; l < 4; l++) begin
            irqLevel <= l[1:0];
            @(posedge mclk);
            #1 chk("accept", {15'h0000, l < 2}, {15'h0000, irqAccept});
        end
        irqLevel <= 2'h0;
        reset <= 1'h1;
        @(posedge mclk);
        reset <= 1'h0;
        rd(4'h6, 16'h0030, "status");
        chk("masked", 16'h0000, {15'h0000, irqAccept});
        irqReq <= 1'h0;
    endtask
    task automatic t_gpr;
        wr(4'h6, 16'h1F00);
        gprSel <= 3'h7;
        gprWrData <= 8'hA5;
        gprWr <= 1'h1;
        @(posedge mclk);
        gprWr <= 1'h0;
        #1 chk("gaddr", 16'h01FF, gprAddr);
        rd(4'h7, 16'h01F8, "bankbase");
        wr(4'h6, 16'h0000);
        gprWrData <= 8'h3C;
        gprWr <= 1'h1;
        @(posedge mclk);
        gprWr <= 1'h0;
        wr(4'h6, 16'h1F00);
        gprRd <= 1'h1;
        @(posedge mclk);
        gprRd <= 1'h0;
        #1 chk("gpr", 16'h00A5, {8'h00, gprRdData});
    endtask
    task automatic close_out;
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        nMismatch++;
        close_out;
    end
    initial begin
        {reset, clkEn} = 2'h3;
        {regWr, regRd, pcInc, aluGo, irqReq, gprWr, gprRd} = 7'h00;
        {regAddr, regWrData, aluOp, flagMask, irqLevel, gprSel, gprWrData} = 41'h0;
        repeat (5) @(posedge mclk);
        reset <= 1'h0;
        rd(4'h6, 16'h0030, "status");
        rd(4'h7, 16'h0100, "bankbase");
        t_regs;
        t_alu(8'h00, 16'h557F, 8'h01, `OP_ADD, 5'h1F, 16'h5580, 8'h8A);
        t_alu(8'h00, 16'h00FF, 8'h01, `OP_ADD, 5'h1F, 16'h0000, 8'h85);
        t_alu(8'h00, 16'h0010, 8'h01, `OP_SUB, 5'h1F, 16'h000F, 8'h80);
        t_alu(8'h00, 16'h0000, 8'h01, `OP_SUB, 5'h1F, 16'h00FF, 8'h89);
        t_alu(8'h00, 16'h0080, 8'h01, `OP_SUB, 5'h1F, 16'h007F, 8'h82);
        t_alu(8'h01, 16'h00F0, 8'h0F, `OP_AND, 5'h1F, 16'h0000, 8'h05);
        t_alu(8'h00, 16'h0080, 8'h01, `OP_OR, 5'h1F, 16'h0081, 8'h08);
        t_alu(8'h01, 16'h0081, 8'h00, `OP_SHL, 5'h0D, 16'h0003, 8'h01);
        t_alu(8'h00, 16'h0001, 8'h00, `OP_SHR, 5'h0D, 16'h0000, 8'h05);
        t_alu(8'h83, 16'h0001, 8'h01, `OP_ADD, 5'h00, 16'h0002, 8'h83);
        t_irq;
        t_gpr;
        close_out;
    end
endmodule // cpu_regs_tb
